/* deadband_if.sv */
/*
 * interface carrying one dead-band delay lane: raw drive in, delayed out.
 * assumes: one clock domain, driven by the top module.
 */
`timescale 1ns/100ps
`default_nettype none

interface deadband_if;
    logic                        raw_active;  // scheduled active level
    logic                        out_active;  // delayed active level
    pwm_shutdown_pkg::dead_count_t count;     // delay in instruction cycles
    modport lane (input raw_active, input count, output out_active);
    modport user (output raw_active, output count, input out_active);
endinterface : deadband_if

`default_nettype wire

/* deadband_lane.sv */
/*
 * delays the inactive-to-active edge of one output by a count of
 * instruction cycles; the active-to-inactive edge passes at once.
 * assumes: tcy_tick is a one-cycle pulse every instruction cycle.
 */
`timescale 1ns/100ps
`default_nettype none

module deadband_lane (
    // clock and reset
    input  wire logic   sys_clk,
    input  wire logic   rst_b,
    // instruction cycle enable
    input  wire logic   tcy_tick,
    // lane signals
    deadband_if.lane    lane
);
    import pwm_shutdown_pkg::*;

    dead_count_t wait_ff;
    logic        out_ff;

    // ------------------------------------------------------------------
    // delay counter
    // ------------------------------------------------------------------
    // an active period shorter than the count ends before the counter
    // runs out, so the lane stays inactive the whole cycle
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_ff <= 7'h00;
            out_ff  <= 1'b0;
        end else if (!lane.raw_active) begin
            wait_ff <= 7'h00;
            out_ff  <= 1'b0;
        end else if (!out_ff) begin
            if (wait_ff >= lane.count) begin
                out_ff <= 1'b1;
            end else if (tcy_tick) begin
                wait_ff <= wait_ff + 7'h01;
            end
        end
    end

    assign lane.out_active = out_ff;
endmodule : deadband_lane

`default_nettype wire

/* half_bridge_switch.sv */
/*
 * half-bridge power switch pair driven by the two pwm pins.
 * assumes: external pull-downs keep a released pin, and its switch, off.
 */
`timescale 1ns/100ps
`default_nettype none

module half_bridge_switch (
    // pins from the block
    input  wire logic pwm_out_a,
    input  wire logic pwm_out_a_oe_b,
    input  wire logic pwm_out_b,
    input  wire logic pwm_out_b_oe_b,
    // switch states
    output logic      high_on,
    output logic      low_on,
    output logic      shoot_through
);
    // a released pin reads the pull-down level, never its last driven value
    assign high_on       = !pwm_out_a_oe_b && pwm_out_a;
    assign low_on        = !pwm_out_b_oe_b && pwm_out_b;
    assign shoot_through = high_on && low_on;
endmodule : half_bridge_switch

`default_nettype wire

/* pwm_shutdown_checker.sv */
/*
 * port assertions for pwm_shutdown_deadband.
 * assumes: bound to the design; register fields are shadowed from taken writes.
 */
`timescale 1ns/100ps
`default_nettype none
`include "pwm_shutdown_consts.svh"

module pwm_shutdown_checker (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // wishbone
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_ack_o,
    // pwm, trigger and pins
    input  wire logic        pwm_raw,
    input  wire logic        period_start,
    input  wire logic        int_pin,
    input  wire logic        pwm_out_a,
    input  wire logic        pwm_out_a_oe_b,
    input  wire logic        pwm_out_b,
    input  wire logic        pwm_out_b_oe_b
);
    // ------------------------------------------------------------
    // register shadows
    // ------------------------------------------------------------
    logic [7:0] sd_ff;
    logic [7:0] rd_ff;
    wire  logic take_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];

    // the flag bit is hardware-owned, so only the written fields are trusted
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sd_ff <= 8'h00;
            rd_ff <= 8'h00;
        end else if (take_wr && wb_adr_i == `OFS_SHUTDOWN_CONTROL) begin
            sd_ff <= wb_dat_i[7:0];
        end else if (take_wr && wb_adr_i == `OFS_RESTART_DEADBAND) begin
            rd_ff <= wb_dat_i[7:0];
        end
    end

    // pin level and enable that a safe-state code asks for
    function automatic logic safe_ok(input logic [1:0] st, input logic lvl, input logic oe_b);
        return st[1] ? (oe_b && !lvl) : (!oe_b && lvl == st[0]);
    endfunction : safe_ok

    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    a_pin_safe_a : assert property (
        sd_ff[6] && !int_pin |=> safe_ok(sd_ff[3:2], pwm_out_a, pwm_out_a_oe_b))
        else $error("output a not in its safe state during pin shutdown");
    a_pin_safe_b : assert property (
        sd_ff[6] && !int_pin |=> safe_ok(sd_ff[1:0], pwm_out_b, pwm_out_b_oe_b))
        else $error("output b not in its safe state during pin shutdown");
    a_ack_next_cycle : assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not acknowledged one cycle after it was taken");
    a_ack_single_pulse : assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge stood longer than one cycle");
    a_resume_at_period : assert property (
        $fell(pwm_out_a_oe_b) && sd_ff[3] |-> $past(period_start, 2))
        else $error("output a driven again away from a period start");
    a_fall_a_fast : assert property (
        $fell(pwm_raw) && sd_ff[3] && !pwm_out_a_oe_b |-> ##2 !pwm_out_a)
        else $error("inactive edge of output a was delayed");
    a_fall_b_fast : assert property (
        $rose(pwm_raw) && sd_ff[1] && !pwm_out_b_oe_b |-> ##2 !pwm_out_b)
        else $error("output b did not follow the complement promptly");
    a_rise_a_late : assert property (
        $rose(pwm_raw) && sd_ff[3] && !pwm_out_a_oe_b && rd_ff[6:0] == 7'h02
        |=> !pwm_out_a [*4])
        else $error("active edge of output a came before its dead band");
endmodule : pwm_shutdown_checker

bind pwm_shutdown_deadband pwm_shutdown_checker i_pwm_shutdown_checker (
    .sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_ack_o(wb_ack_o), .pwm_raw(pwm_raw), .period_start(period_start),
    .int_pin(int_pin), .pwm_out_a(pwm_out_a), .pwm_out_a_oe_b(pwm_out_a_oe_b),
    .pwm_out_b(pwm_out_b), .pwm_out_b_oe_b(pwm_out_b_oe_b));

`default_nettype wire

/* pwm_shutdown_consts.svh */
/*
 * register offsets, field positions, reset values and timing counts
 * of the pwm shutdown and dead-band block.
 * assumes: included by bare name from the package and the checker.
 */
`ifndef PWM_SHUTDOWN_CONSTS_SVH
`define PWM_SHUTDOWN_CONSTS_SVH

// ----------------------------------------------------------------------
// register byte offsets on the wishbone bus
// ----------------------------------------------------------------------
`define OFS_SHUTDOWN_CONTROL        4'h0
`define OFS_RESTART_DEADBAND        4'h4
`define OFS_IRQ_STATUS              4'h8
`define OFS_IRQ_MASK                4'hC

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define SD_FLAG_BIT                 7
`define SD_SRC_HI                   6
`define SD_SRC_LO                   4
`define SD_SAFE_A_HI                3
`define SD_SAFE_A_LO                2
`define SD_SAFE_B_HI                1
`define SD_SAFE_B_LO                0
`define RD_AUTO_BIT                 7
`define RD_COUNT_HI                 6
`define RD_COUNT_LO                 0
`define IRQ_SHUTDOWN_BIT            0
`define IRQ_RESUME_BIT              1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_SHUTDOWN_CONTROL        8'h00
`define RST_RESTART_DEADBAND        8'h00
`define RST_IRQ                     2'h0

// ----------------------------------------------------------------------
// timing: instruction cycle is four oscillator periods; the oscillator
// period is taken as one sys_clk period, so the tick divides by four
// ----------------------------------------------------------------------
`define TOSC_PER_TCY                4
`define TCY_DIV_CYCLES              (`TOSC_PER_TCY)

`endif

/* pwm_shutdown_deadband.sv */
/*
 * auto-shutdown, restart and half-bridge dead-band stage of a pwm
 * output pair, with a classic wishbone register slave and interrupt.
 * assumes: pwm_raw comes from a base generator on sys_clk, period_start
 * is a one-cycle pulse at each period start, inputs are synchronous.
 */
// Chosen here: the Wishbone slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module pwm_shutdown_deadband (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // base pwm and triggers
    input  wire logic        pwm_raw,
    input  wire logic        period_start,
    input  wire logic        comparator_out,
    input  wire logic        comparator_timer_sync,
    input  wire logic        timer_sync_tick,
    input  wire logic        int_pin,
    // half-bridge pins, oe low while driving
    output logic             pwm_out_a,
    output logic             pwm_out_a_oe_b,
    output logic             pwm_out_b,
    output logic             pwm_out_b_oe_b,
    // status
    output logic             irq
);
    import pwm_shutdown_pkg::*;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic        shutdown_event_flag_ff;
    src_sel_t    shutdown_source_select_ff;
    safe_state_t out_a_safe_state_ff;
    safe_state_t out_b_safe_state_ff;
    logic        auto_restart_enable_ff;
    dead_count_t deadband_count_ff;
    logic [1:0]  irq_status_ff;
    logic [1:0]  irq_mask_ff;
    run_state_e  state_ff;
    run_state_e  nxt_state;
    logic        cmp_prev_ff;
    logic        cmp_sync_ff;
    logic        cmp_level;
    logic        cmp_change;
    logic [1:0]  tcy_div_ff;
    logic        tcy_tick;
    logic        wb_ack_ff;
    logic [31:0] wb_dat_ff;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // safe level for a pin: returns {drive, level}; drive low means hi-z
    function automatic logic [1:0] safe_drive(input safe_state_t sel);
        safe_drive = {~sel[1], sel[0] & ~sel[1]};
    endfunction : safe_drive

    // bus write on an offset, applied at the edge that sees ack high
    function automatic logic wr_hit(input logic [3:0] ofs);
        wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_ff
                 && wb_sel_i[0] && (wb_adr_i == ofs);
    endfunction : wr_hit

    // ------------------------------------------------------------------
    // trigger conditions
    // ------------------------------------------------------------------
    // comparator change: with the sync option on, the level is only taken
    // on the sync tick, which adds the timer's delay
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cmp_prev_ff <= 1'b0;
            cmp_sync_ff <= 1'b0;
        end else begin
            cmp_prev_ff <= cmp_level;
            if (!comparator_timer_sync || timer_sync_tick) begin
                cmp_sync_ff <= comparator_out;
            end
        end
    end

    // change pulses for one cycle when the compared level toggles: edge based
    assign cmp_level  = comparator_timer_sync ? cmp_sync_ff : comparator_out;
    assign cmp_change = (cmp_level != cmp_prev_ff);

    logic cmp_trigger;
    logic pin_trigger;
    logic condition;
    assign cmp_trigger = shutdown_source_select_ff[0] && cmp_change;
    assign pin_trigger = shutdown_source_select_ff[2] && !int_pin;
    assign condition   = cmp_trigger || pin_trigger;

    // ------------------------------------------------------------------
    // shutdown flag
    // ------------------------------------------------------------------
    logic flag_wr;
    assign flag_wr = wr_hit(`OFS_SHUTDOWN_CONTROL);

    // the condition always wins over a software clear
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            shutdown_event_flag_ff <= 1'b0;
        end else if (condition) begin
            shutdown_event_flag_ff <= 1'b1;
        end else if (flag_wr) begin
            shutdown_event_flag_ff <= wb_dat_i[`SD_FLAG_BIT];
        end else if (auto_restart_enable_ff && shutdown_event_flag_ff) begin
            shutdown_event_flag_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            shutdown_source_select_ff <= 3'h0;
            out_a_safe_state_ff       <= 2'h0;
            out_b_safe_state_ff       <= 2'h0;
        end else if (flag_wr) begin
            shutdown_source_select_ff <= wb_dat_i[`SD_SRC_HI:`SD_SRC_LO];
            out_a_safe_state_ff <= wb_dat_i[`SD_SAFE_A_HI:`SD_SAFE_A_LO];
            out_b_safe_state_ff <= wb_dat_i[`SD_SAFE_B_HI:`SD_SAFE_B_LO];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            auto_restart_enable_ff <= 1'b0;
            deadband_count_ff      <= 7'h00;
        end else if (wr_hit(`OFS_RESTART_DEADBAND)) begin
            auto_restart_enable_ff <= wb_dat_i[`RD_AUTO_BIT];
            deadband_count_ff      <= wb_dat_i[`RD_COUNT_HI:`RD_COUNT_LO];
        end
    end

    // ------------------------------------------------------------------
    // run state: resume waits for a period boundary
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            RUN: begin
                if (shutdown_event_flag_ff) nxt_state = HELD;
            end
            HELD: begin
                if (!shutdown_event_flag_ff) nxt_state = WAIT_PERIOD;
            end
            WAIT_PERIOD: begin
                if (shutdown_event_flag_ff) nxt_state = HELD;
                else if (period_start) nxt_state = RUN;
            end
            default: nxt_state = HELD;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= RUN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------------
    // instruction cycle tick and dead-band lanes
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tcy_div_ff <= 2'h0;
        end else begin
            tcy_div_ff <= tcy_div_ff + 2'h1;
        end
    end
    assign tcy_tick = (tcy_div_ff == 2'(`TCY_DIV_CYCLES - 1));

    deadband_if lane_a_if ();
    deadband_if lane_b_if ();
    assign lane_a_if.raw_active = pwm_raw;
    assign lane_b_if.raw_active = !pwm_raw;
    assign lane_a_if.count      = deadband_count_ff;
    assign lane_b_if.count      = deadband_count_ff;

    deadband_lane lane_a (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .tcy_tick (tcy_tick),
        .lane     (lane_a_if.lane)
    );
    deadband_lane lane_b (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .tcy_tick (tcy_tick),
        .lane     (lane_b_if.lane)
    );

    // ------------------------------------------------------------------
    // output stage
    // ------------------------------------------------------------------
    // outputs are registered; shutdown takes them one edge after the
    // trigger is seen, the closest a one-flop-out design gets
    logic shut_now;
    logic [1:0] safe_a;
    logic [1:0] safe_b;
    assign shut_now = condition || shutdown_event_flag_ff || (state_ff != RUN);
    assign safe_a   = safe_drive(out_a_safe_state_ff);
    assign safe_b   = safe_drive(out_b_safe_state_ff);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pwm_out_a      <= 1'b0;
            pwm_out_a_oe_b <= 1'b1;
            pwm_out_b      <= 1'b0;
            pwm_out_b_oe_b <= 1'b1;
        end else if (shut_now) begin
            pwm_out_a      <= safe_a[0];
            pwm_out_a_oe_b <= !safe_a[1];
            pwm_out_b      <= safe_b[0];
            pwm_out_b_oe_b <= !safe_b[1];
        end else begin
            pwm_out_a      <= lane_a_if.out_active;
            pwm_out_a_oe_b <= 1'b0;
            pwm_out_b      <= lane_b_if.out_active;
            pwm_out_b_oe_b <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // interrupts: bit 0 shutdown entered, bit 1 pwm resumed
    // ------------------------------------------------------------------
    logic [1:0] irq_event;
    logic [1:0] irq_clear;
    assign irq_event = {(state_ff == WAIT_PERIOD) && (nxt_state == RUN),
                        (state_ff == RUN) && (nxt_state == HELD)};
    assign irq_clear = wr_hit(`OFS_IRQ_STATUS) ? wb_dat_i[1:0] : 2'h0;

    // set wins over a clear in the same cycle
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_status_ff <= `RST_IRQ;
        end else begin
            irq_status_ff <= (irq_status_ff & ~irq_clear) | irq_event;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_mask_ff <= `RST_IRQ;
        end else if (wr_hit(`OFS_IRQ_MASK)) begin
            irq_mask_ff <= wb_dat_i[1:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((irq_status_ff & ~irq_clear) | irq_event) & irq_mask_ff);
        end
    end

    // ------------------------------------------------------------------
    // wishbone answer: ack one cycle after the request, then drop
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wb_ack_ff <= 1'b0;
            wb_dat_ff <= 32'h0000_0000;
        end else begin
            wb_ack_ff <= wb_cyc_i && wb_stb_i && !wb_ack_ff;
            case (wb_adr_i)
                `OFS_SHUTDOWN_CONTROL: wb_dat_ff <= {24'h00_0000,
                    shutdown_event_flag_ff, shutdown_source_select_ff,
                    out_a_safe_state_ff, out_b_safe_state_ff};
                `OFS_RESTART_DEADBAND: wb_dat_ff <= {24'h00_0000,
                    auto_restart_enable_ff, deadband_count_ff};
                `OFS_IRQ_STATUS:       wb_dat_ff <= {30'h0000_0000, irq_status_ff};
                `OFS_IRQ_MASK:         wb_dat_ff <= {30'h0000_0000, irq_mask_ff};
                default:               wb_dat_ff <= 32'h0000_0000;
            endcase
        end
    end

    assign wb_ack_o = wb_ack_ff;
    assign wb_dat_o = wb_dat_ff;
endmodule : pwm_shutdown_deadband

`default_nettype wire

/* pwm_shutdown_pkg.sv */
/*
 * types shared by the pwm shutdown block and its submodules.
 * assumes: the constants header is in the same folder.
 */
`include "pwm_shutdown_consts.svh"

package pwm_shutdown_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [6:0] dead_count_t;
    typedef logic [1:0] safe_state_t;
    typedef logic [2:0] src_sel_t;
    // pwm output phase of the shutdown controller
    typedef enum logic [1:0] {
        RUN,
        HELD,
        WAIT_PERIOD
    } run_state_e;
endpackage : pwm_shutdown_pkg

/* test_pwm_shutdown_deadband.sv */
/*
 * self-checking bench: registers over wishbone, shutdown, restart, dead band.
 * assumes: design, package, checker and switch model compiled before it.
 */
`timescale 1ns/100ps
`default_nettype none

module test_pwm_shutdown_deadband;
    import pwm_shutdown_pkg::*;
    logic        sys_clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
    logic [3:0]  wb_adr_i, wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic        pwm_raw, period_start, comparator_out, comparator_timer_sync;
    logic        timer_sync_tick, int_pin, pwm_out_a, pwm_out_a_oe_b, pwm_out_b;
    logic        pwm_out_b_oe_b, high_on, low_on, shoot_through, seen;
    int          mismatches, cmp_count, shoots;

    pwm_shutdown_deadband i_pwm_shutdown_deadband (
        .sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pwm_raw(pwm_raw),
        .period_start(period_start), .comparator_out(comparator_out),
        .comparator_timer_sync(comparator_timer_sync), .timer_sync_tick(timer_sync_tick),
        .int_pin(int_pin), .pwm_out_a(pwm_out_a), .pwm_out_a_oe_b(pwm_out_a_oe_b),
        .pwm_out_b(pwm_out_b), .pwm_out_b_oe_b(pwm_out_b_oe_b), .irq(irq));
    half_bridge_switch i_half_bridge_switch (.pwm_out_a(pwm_out_a),
        .pwm_out_a_oe_b(pwm_out_a_oe_b), .pwm_out_b(pwm_out_b),
        .pwm_out_b_oe_b(pwm_out_b_oe_b), .high_on(high_on), .low_on(low_on),
        .shoot_through(shoot_through));

    // ------------------------------------------------------------
    // clock, shoot-through monitor and watchdog
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'h0;
        forever #2 sys_clk = ~sys_clk;
    end
    // both switches on would short the bridge supply
    always @(posedge sys_clk) if (shoot_through === 1'h1) shoots++;
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        $display("watchdog expired");
        finish_test();
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic finish_test;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one classic cycle; held until ack, released at the ack edge
    task automatic wb(input logic we, input logic [3:0] adr, input logic [7:0] wd);
        int n;
        @(posedge sys_clk);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {24'h00_0000, wd};
        wb_sel_i <= 4'hf;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 20);
        rd = wb_dat_o;
        chk(wb_ack_o, 1'h1);
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
    endtask : wb

    task automatic rdc(input logic [3:0] adr, input logic [7:0] exp);
        wb(1'h0, adr, 8'h00);
        chk(rd, {24'h00_0000, exp});
    endtask : rdc

    task automatic pins(input logic [3:0] exp);
        chk({pwm_out_a, pwm_out_a_oe_b, pwm_out_b, pwm_out_b_oe_b}, exp);
    endtask : pins

    task automatic restart;
        repeat (3) @(posedge sys_clk);
        period_start <= 1'h1;
        @(posedge sys_clk);
        period_start <= 1'h0;
        repeat (3) @(posedge sys_clk);
    endtask : restart

    // the output going active trails the one going inactive by c cycles of four
    task automatic lag(input logic lvl, input int c);
        int t_a;
        int t_b;
        int d;
        t_a = 0;
        t_b = 0;
        @(posedge sys_clk);
        pwm_raw <= lvl;
        for (int i = 1; i < 48; i++) begin
            @(posedge sys_clk);
            if (t_a == 0 && pwm_out_a === lvl) t_a = i;
            if (t_b == 0 && pwm_out_b === !lvl) t_b = i;
        end
        d = lvl ? t_a - t_b : t_b - t_a;
        chk(t_a > 0 && t_b > 0 && d >= (c == 0 ? 0 : 4 * c - 3) && d <= 4 * c, 1'h1);
    endtask : lag

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_b, wb_cyc_i, wb_stb_i, wb_we_i, pwm_raw, period_start} = 6'h00;
        {comparator_out, comparator_timer_sync, timer_sync_tick} = 3'h0;
        {wb_adr_i, wb_sel_i, wb_dat_i, int_pin} = {40'h00_0000_0000, 1'h1};
        repeat (6) @(posedge sys_clk);
        pins(4'h5);
        chk(irq, 1'h0);
        rst_b <= 1'h1;
        rdc(4'h0, 8'h00);
        rdc(4'h4, 8'h00);
        rdc(4'h8, 8'h00);
        rdc(4'hc, 8'h00);
        wb(1'h1, 4'h2, 8'hff);
        rdc(4'h2, 8'h00);
        wb(1'h1, 4'h0, 8'h6f);
        rdc(4'h0, 8'h6f);
        wb(1'h1, 4'h4, 8'h7f);
        rdc(4'h4, 8'h7f);
        $display("register test done");
        wb(1'h1, 4'h0, 8'h0a);
        restart();
        for (int c = 0; c < 8; c += 7) begin
            wb(1'h1, 4'h4, c[7:0]);
            lag(1'h1, c);
            lag(1'h0, c);
        end
        wb(1'h1, 4'h4, 8'h02);
        lag(1'h1, 2);
        lag(1'h0, 2);
        wb(1'h1, 4'h4, 8'h04);
        seen = 1'h0;
        pwm_raw <= 1'h1;
        for (int i = 0; i < 30; i++) begin
            @(posedge sys_clk);
            if (i == 5) pwm_raw <= 1'h0;
            if (pwm_out_a !== 1'h0) seen = 1'h1;
        end
        chk(seen, 1'h0);
        chk(shoots, 0);
        $display("dead band test done");
        wb(1'h1, 4'hc, 8'h03);
        wb(1'h1, 4'h0, 8'h44);
        int_pin <= 1'h0;
        repeat (3) @(posedge sys_clk);
        pins(4'h8);
        chk(irq, 1'h1);
        repeat (10) @(posedge sys_clk);
        pins(4'h8);
        wb(1'h1, 4'h0, 8'h44);
        rdc(4'h0, 8'hc4);
        int_pin <= 1'h1;
        repeat (3) @(posedge sys_clk);
        rdc(4'h0, 8'hc4);
        wb(1'h1, 4'h0, 8'h44);
        rdc(4'h0, 8'h44);
        pins(4'h8);
        restart();
        pins(4'h2);
        rdc(4'h8, 8'h03);
        wb(1'h1, 4'h8, 8'h03);
        wb(1'h1, 4'hc, 8'h00);
        wb(1'h1, 4'h0, 8'h8a);
        repeat (2) @(posedge sys_clk);
        pins(4'h5);
        rdc(4'h0, 8'h8a);
        chk(irq, 1'h0);
        wb(1'h1, 4'h0, 8'h0a);
        restart();
        pins(4'h2);
        $display("shutdown test done");
        wb(1'h1, 4'h4, 8'h80);
        for (int s = 0; s < 8; s++) begin
            wb(1'h1, 4'h0, {1'h0, s[2:0], 4'ha});
            int_pin <= 1'h0;
            repeat (3) @(posedge sys_clk);
            chk(pwm_out_a_oe_b, s[2]);
            int_pin <= 1'h1;
            repeat (3) @(posedge sys_clk);
            rdc(4'h0, {1'h0, s[2:0], 4'ha});
            restart();
            {comparator_timer_sync, timer_sync_tick} <= {s[1], 1'h0};
            comparator_out <= ~comparator_out;
            repeat (3) @(posedge sys_clk);
            chk(pwm_out_a_oe_b, s[0] & !s[1]);
            timer_sync_tick <= 1'h1;
            repeat (3) @(posedge sys_clk);
            chk(pwm_out_a_oe_b, s[0]);
            restart();
        end
        $display("auto restart test done");
        finish_test();
    end
endmodule : test_pwm_shutdown_deadband

`default_nettype wire
